// [mrp_macro_engine.sv]
`timescale 1ns/1ps
`include "mrp_map.svh"

// Contract
// - Code 0xE000 with a name opens a new macro capturing later commands.
// - Recording under a name already stored overwrites that macro.
// - An open recording captures commands from one source interface only.
// - Code 0xE002 without argument closes the recording and stores it.
// - A read of 0xE004 with a name returns the stored commands as binary.
// - Code 0xE005 picks a default macro run at restart; a read returns it.
// - Code 0xE005 without a name clears the default selection.
// - Code 0xE010 runs a macro count times (1 if omitted); read = status.
// - Code 0xE012 inside a macro pauses playback for that many ms.
// - Names are compared case-sensitively and hold at most 8 characters.
module mrp_macro_engine
	import mrp_pkg::*;
#(
	parameter int CYC_PER_MS = `MRP_CYC_PER_MS
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic restart,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [`MRP_SRC_W-1:0] cmd_src,
	input wire logic cmd_read,
	input wire logic [15:0] cmd_code,
	input wire logic cmd_has_name,
	input wire logic [`MRP_NAME_W-1:0] cmd_name,
	input wire logic cmd_has_arg,
	input wire logic [`MRP_ARG_W-1:0] cmd_arg,
	output logic rsp_valid,
	output logic rsp_last,
	output logic [1:0] rsp_status,
	output logic [`MRP_RSP_W-1:0] rsp_data,
	output logic exec_valid,
	output logic [15:0] exec_code,
	output logic exec_has_name,
	output logic [`MRP_NAME_W-1:0] exec_name,
	output logic exec_has_arg,
	output logic [`MRP_ARG_W-1:0] exec_arg,
	output logic busy
);

	localparam logic [`MRP_CYC_W-1:0] CYC_M1 = `MRP_CYC_W'(CYC_PER_MS - 1);
	localparam logic [`MRP_POS_W-1:0] POS_MAX = `MRP_POS_W'(`MRP_ENTRIES);

	mrp_store_if st ();

	mrp_store u_store (
		.clk(clk),
		.ce(ce),
		.st(st.mem)
	);

	mrp_state_t state, next_state;
	logic [`MRP_SLOTS-1:0] slot_valid, next_slot_valid;
	logic [`MRP_NAME_W-1:0] slot_name [`MRP_SLOTS];
	logic [`MRP_NAME_W-1:0] next_slot_name [`MRP_SLOTS];
	logic [`MRP_POS_W-1:0] slot_len [`MRP_SLOTS];
	logic [`MRP_POS_W-1:0] next_slot_len [`MRP_SLOTS];
	logic rec_on, next_rec_on;
	logic [`MRP_SRC_W-1:0] rec_src, next_rec_src;
	logic [`MRP_SLOT_W-1:0] rec_slot, next_rec_slot;
	logic [`MRP_POS_W-1:0] rec_len, next_rec_len;
	logic dflt_valid, next_dflt_valid;
	logic [`MRP_NAME_W-1:0] dflt_name, next_dflt_name;
	logic [`MRP_SLOT_W-1:0] run_slot, next_run_slot;
	logic [`MRP_POS_W-1:0] run_pos, next_run_pos;
	logic [`MRP_ARG_W-1:0] run_left, next_run_left;
	logic ret_valid, next_ret_valid;
	logic [`MRP_SLOT_W-1:0] ret_slot, next_ret_slot;
	logic [`MRP_POS_W-1:0] ret_pos, next_ret_pos;
	logic [`MRP_ARG_W-1:0] ret_left, next_ret_left;
	logic [`MRP_ARG_W-1:0] ms_left, next_ms_left;
	logic [`MRP_CYC_W-1:0] cyc_cnt, next_cyc_cnt;
	logic [`MRP_POS_W-1:0] walk, next_walk;
	logic [`MRP_SLOT_W-1:0] show_slot, next_show_slot;
	logic next_cmd_ready, next_rsp_valid, next_rsp_last, next_exec_valid;
	logic [1:0] next_rsp_status;
	logic [`MRP_RSP_W-1:0] next_rsp_data;
	logic [15:0] next_exec_code;
	logic next_exec_has_name, next_exec_has_arg, next_busy;
	logic [`MRP_NAME_W-1:0] next_exec_name;
	logic [`MRP_ARG_W-1:0] next_exec_arg;

	logic [`MRP_SLOTS-1:0] cmd_hit, dflt_hit, call_hit, free_slot;
	logic accept;
	mrp_entry_t cur;

	// Exact 64-bit compare keeps names case-sensitive
	genvar g;
	for (g = 0; g < `MRP_SLOTS; g++)
	begin : g_slot
		assign cmd_hit[g] = slot_valid[g] && slot_name[g] == cmd_name;
		assign dflt_hit[g] = slot_valid[g] && slot_name[g] == dflt_name;
		assign call_hit[g] = slot_valid[g] && slot_name[g] == cur.name;
		assign free_slot[g] = !slot_valid[g] &&
			!(rec_on && rec_slot == `MRP_SLOT_W'(g));
	end

	function automatic logic [`MRP_SLOT_W-1:0] first(
		input logic [`MRP_SLOTS-1:0] v);
		logic [`MRP_SLOT_W-1:0] r;
		r = '0;
		for (int i = `MRP_SLOTS - 1; i >= 0; i--)
		begin
			if (v[i])
			begin
				r = `MRP_SLOT_W'(i);
			end
		end
		return r;
	endfunction

	assign accept = cmd_valid && cmd_ready;
	assign cur = st.rd_data;

	always_comb
	begin
		next_state = state;
		next_slot_valid = slot_valid;
		next_slot_name = slot_name;
		next_slot_len = slot_len;
		next_rec_on = rec_on;
		next_rec_src = rec_src;
		next_rec_slot = rec_slot;
		next_rec_len = rec_len;
		next_dflt_valid = dflt_valid;
		next_dflt_name = dflt_name;
		next_run_slot = run_slot;
		next_run_pos = run_pos;
		next_run_left = run_left;
		next_ret_valid = ret_valid;
		next_ret_slot = ret_slot;
		next_ret_pos = ret_pos;
		next_ret_left = ret_left;
		next_ms_left = ms_left;
		next_cyc_cnt = cyc_cnt;
		next_walk = walk;
		next_show_slot = show_slot;
		next_rsp_valid = 1'b0;
		next_rsp_last = 1'b0;
		next_rsp_status = `MRP_ST_OK;
		next_rsp_data = '0;
		next_exec_valid = 1'b0;
		next_exec_code = exec_code;
		next_exec_has_name = exec_has_name;
		next_exec_name = exec_name;
		next_exec_has_arg = exec_has_arg;
		next_exec_arg = exec_arg;
		st.wr_en = 1'b0;
		st.wr_addr = {rec_slot, rec_len[`MRP_POS_W-2:0]};
		st.wr_data = '{code: cmd_code, has_name: cmd_has_name,
			name: cmd_name, has_arg: cmd_has_arg, arg: cmd_arg};
		if (state == S_SHOW)
		begin
			st.rd_addr = {show_slot, walk[`MRP_POS_W-2:0]};
		end
		else
		begin
			st.rd_addr = {run_slot, run_pos[`MRP_POS_W-2:0]};
		end
		if (accept)
		begin
			next_rsp_valid = 1'b1;
			next_rsp_last = 1'b1;
			if (rec_on && cmd_src == rec_src && cmd_code != `MRP_OP_REC_END)
			begin
				// Captured, not executed
				if (rec_len == POS_MAX)
				begin
					next_rsp_status = `MRP_ST_FULL;
				end
				else
				begin
					st.wr_en = 1'b1;
					next_rec_len = rec_len + 1'b1;
				end
			end
			else if (cmd_code == `MRP_OP_REC_START)
			begin
				if (|cmd_hit || |free_slot)
				begin
					// Matching name reuses its slot
					next_rec_slot = |cmd_hit ? first(cmd_hit) : first(free_slot);
					next_slot_valid[next_rec_slot] = 1'b0;
					next_slot_name[next_rec_slot] = cmd_name;
					next_rec_on = 1'b1;
					next_rec_src = cmd_src;
					next_rec_len = '0;
				end
				else
				begin
					next_rsp_status = `MRP_ST_FULL;
				end
			end
			else if (cmd_code == `MRP_OP_REC_END)
			begin
				if (rec_on && cmd_src == rec_src)
				begin
					next_rec_on = 1'b0;
					next_slot_valid[rec_slot] = 1'b1;
					next_slot_len[rec_slot] = rec_len;
				end
			end
			else if (cmd_code == `MRP_OP_LIST)
			begin
				next_rsp_valid = 1'b0;
				next_walk = '0;
				next_state = S_LIST;
			end
			else if (cmd_code == `MRP_OP_SHOW)
			begin
				if (|cmd_hit)
				begin
					next_rsp_valid = 1'b0;
					next_show_slot = first(cmd_hit);
					next_walk = '0;
					next_state = S_SHOW;
				end
				else
				begin
					next_rsp_status = `MRP_ST_NO_NAME;
				end
			end
			else if (cmd_code == `MRP_OP_DEFAULT)
			begin
				if (cmd_read)
				begin
					next_rsp_data = `MRP_RSP_W'({dflt_valid, dflt_name});
				end
				else
				begin
					next_dflt_valid = cmd_has_name;
					next_dflt_name = cmd_has_name ? cmd_name : '0;
				end
			end
			else if (cmd_code == `MRP_OP_DELETE)
			begin
				if (|cmd_hit)
				begin
					next_slot_valid[first(cmd_hit)] = 1'b0;
				end
				else
				begin
					next_rsp_status = `MRP_ST_NO_NAME;
				end
			end
			else if (cmd_code == `MRP_OP_RUN)
			begin
				if (cmd_read)
				begin
					next_rsp_data = `MRP_RSP_W'(busy);
				end
				else if (|cmd_hit)
				begin
					next_run_slot = first(cmd_hit);
					next_run_pos = '0;
					next_run_left = (cmd_has_arg && cmd_arg != '0) ?
						cmd_arg : `MRP_ARG_W'(1);
					next_ret_valid = 1'b0;
					next_state = S_RUN;
				end
				else
				begin
					next_rsp_status = `MRP_ST_NO_NAME;
				end
			end
			else if (cmd_code == `MRP_OP_STOP)
			begin
				next_ret_valid = 1'b0;
				next_state = S_IDLE;
			end
			else if (cmd_code != `MRP_OP_DELAY)
			begin
				// Not a macro command: hand on to the interpreter
				next_rsp_valid = 1'b0;
				next_rsp_last = 1'b0;
				next_exec_valid = 1'b1;
				next_exec_code = cmd_code;
				next_exec_has_name = cmd_has_name;
				next_exec_name = cmd_name;
				next_exec_has_arg = cmd_has_arg;
				next_exec_arg = cmd_arg;
			end
		end
		else
		begin
			case (state)
				S_IDLE:
				begin
					if (restart && dflt_valid && |dflt_hit)
					begin
						next_run_slot = first(dflt_hit);
						next_run_pos = '0;
						next_run_left = `MRP_ARG_W'(1);
						next_ret_valid = 1'b0;
						next_state = S_RUN;
					end
				end
				S_LIST:
				begin
					next_rsp_valid = 1'b1;
					if (walk == `MRP_POS_W'(`MRP_SLOTS))
					begin
						next_rsp_last = 1'b1;
						next_state = S_IDLE;
					end
					else
					begin
						next_rsp_valid = slot_valid[walk[`MRP_SLOT_W-1:0]];
						next_rsp_data =
							`MRP_RSP_W'(slot_name[walk[`MRP_SLOT_W-1:0]]);
						next_walk = walk + 1'b1;
					end
				end
				S_SHOW:
				begin
					next_rsp_valid = 1'b1;
					if (walk == slot_len[show_slot])
					begin
						next_rsp_last = 1'b1;
						next_state = S_IDLE;
					end
					else
					begin
						next_rsp_data = `MRP_RSP_W'(cur);
						next_walk = walk + 1'b1;
					end
				end
				S_RUN:
				begin
					if (!slot_valid[run_slot])
					begin
						next_state = S_IDLE;
					end
					else if (run_pos == slot_len[run_slot])
					begin
						if (run_left > `MRP_ARG_W'(1))
						begin
							next_run_left = run_left - 1'b1;
							next_run_pos = '0;
						end
						else if (ret_valid)
						begin
							next_ret_valid = 1'b0;
							next_run_slot = ret_slot;
							next_run_pos = ret_pos;
							next_run_left = ret_left;
						end
						else
						begin
							next_state = S_IDLE;
						end
					end
					else
					begin
						next_run_pos = run_pos + 1'b1;
						if (cur.code == `MRP_OP_DELAY)
						begin
							if (cur.arg != '0)
							begin
								next_ms_left = cur.arg;
								next_cyc_cnt = '0;
								next_state = S_DELAY;
							end
						end
						else if (cur.code == `MRP_OP_RUN && !ret_valid && |call_hit)
						begin
							// One level of nested call
							next_ret_valid = 1'b1;
							next_ret_slot = run_slot;
							next_ret_pos = run_pos + 1'b1;
							next_ret_left = run_left;
							next_run_slot = first(call_hit);
							next_run_pos = '0;
							next_run_left = (cur.has_arg && cur.arg != '0) ?
								cur.arg : `MRP_ARG_W'(1);
						end
						else
						begin
							next_exec_valid = 1'b1;
							next_exec_code = cur.code;
							next_exec_has_name = cur.has_name;
							next_exec_name = cur.name;
							next_exec_has_arg = cur.has_arg;
							next_exec_arg = cur.arg;
						end
					end
				end
				S_DELAY:
				begin
					if (cyc_cnt == CYC_M1)
					begin
						next_cyc_cnt = '0;
						next_ms_left = ms_left - 1'b1;
						if (ms_left == `MRP_ARG_W'(1))
						begin
							next_state = S_RUN;
						end
					end
					else
					begin
						next_cyc_cnt = cyc_cnt + 1'b1;
					end
				end
				default:
				begin
					next_state = S_IDLE;
				end
			endcase
		end
		next_cmd_ready = next_state == S_IDLE || next_state == S_RUN ||
			next_state == S_DELAY;
		next_busy = next_state == S_RUN || next_state == S_DELAY;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state <= S_IDLE;
			slot_valid <= '0;
			slot_name <= '{default: '0};
			slot_len <= '{default: '0};
			rec_on <= 1'b0;
			rec_src <= '0;
			rec_slot <= '0;
			rec_len <= '0;
			dflt_valid <= 1'b0;
			dflt_name <= '0;
			run_slot <= '0;
			run_pos <= '0;
			run_left <= '0;
			ret_valid <= 1'b0;
			ret_slot <= '0;
			ret_pos <= '0;
			ret_left <= '0;
			ms_left <= '0;
			cyc_cnt <= '0;
			walk <= '0;
			show_slot <= '0;
			cmd_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_last <= 1'b0;
			rsp_status <= `MRP_ST_OK;
			rsp_data <= '0;
			exec_valid <= 1'b0;
			exec_code <= '0;
			exec_has_name <= 1'b0;
			exec_name <= '0;
			exec_has_arg <= 1'b0;
			exec_arg <= '0;
			busy <= 1'b0;
		end
		else if (ce)
		begin
			state <= next_state;
			slot_valid <= next_slot_valid;
			slot_name <= next_slot_name;
			slot_len <= next_slot_len;
			rec_on <= next_rec_on;
			rec_src <= next_rec_src;
			rec_slot <= next_rec_slot;
			rec_len <= next_rec_len;
			dflt_valid <= next_dflt_valid;
			dflt_name <= next_dflt_name;
			run_slot <= next_run_slot;
			run_pos <= next_run_pos;
			run_left <= next_run_left;
			ret_valid <= next_ret_valid;
			ret_slot <= next_ret_slot;
			ret_pos <= next_ret_pos;
			ret_left <= next_ret_left;
			ms_left <= next_ms_left;
			cyc_cnt <= next_cyc_cnt;
			walk <= next_walk;
			show_slot <= next_show_slot;
			cmd_ready <= next_cmd_ready;
			rsp_valid <= next_rsp_valid;
			rsp_last <= next_rsp_last;
			rsp_status <= next_rsp_status;
			rsp_data <= next_rsp_data;
			exec_valid <= next_exec_valid;
			exec_code <= next_exec_code;
			exec_has_name <= next_exec_has_name;
			exec_name <= next_exec_name;
			exec_has_arg <= next_exec_has_arg;
			exec_arg <= next_exec_arg;
			busy <= next_busy;
		end
	end

endmodule

// [mrp_map.svh]
`ifndef MRP_MAP_SVH
`define MRP_MAP_SVH

// Command codes
`define MRP_OP_REC_START 16'hE000
`define MRP_OP_REC_END 16'hE002
`define MRP_OP_LIST 16'hE003
`define MRP_OP_SHOW 16'hE004
`define MRP_OP_DEFAULT 16'hE005
`define MRP_OP_DELETE 16'hE006
`define MRP_OP_RUN 16'hE010
`define MRP_OP_STOP 16'hE011
`define MRP_OP_DELAY 16'hE012

// Storage geometry
`define MRP_SLOTS 4
`define MRP_SLOT_W 2
`define MRP_ENTRIES 16
`define MRP_POS_W 5
`define MRP_ADDR_W 6
`define MRP_NAME_W 64
`define MRP_ARG_W 32
`define MRP_RSP_W 128
`define MRP_SRC_W 2

// Answer status codes
`define MRP_ST_OK 2'h0
`define MRP_ST_NO_NAME 2'h1
`define MRP_ST_FULL 2'h2

// Timing
`define MRP_MS_NS 1000000
`define MRP_CLK_NS 5
`define MRP_CYC_PER_MS (`MRP_MS_NS / `MRP_CLK_NS)
`define MRP_CYC_W 18

`endif

// [mrp_pkg.sv]
`include "mrp_map.svh"

package mrp_pkg;

	typedef struct packed {
		logic [15:0] code;
		logic has_name;
		logic [`MRP_NAME_W-1:0] name;
		logic has_arg;
		logic [`MRP_ARG_W-1:0] arg;
	} mrp_entry_t;

	typedef enum logic [4:0] {
		S_IDLE = 5'b00001,
		S_LIST = 5'b00010,
		S_SHOW = 5'b00100,
		S_RUN = 5'b01000,
		S_DELAY = 5'b10000
	} mrp_state_t;

endpackage

// [mrp_store_if.sv]
`timescale 1ns/1ps
`include "mrp_map.svh"

interface mrp_store_if;
	import mrp_pkg::*;
	logic wr_en;
	logic [`MRP_ADDR_W-1:0] wr_addr;
	mrp_entry_t wr_data;
	logic [`MRP_ADDR_W-1:0] rd_addr;
	mrp_entry_t rd_data;

	modport owner (output wr_en, output wr_addr, output wr_data,
		output rd_addr, input rd_data);
	modport mem (input wr_en, input wr_addr, input wr_data,
		input rd_addr, output rd_data);
endinterface

// [mrp_store.sv]
`timescale 1ns/1ps
`include "mrp_map.svh"

module mrp_store
	import mrp_pkg::*;
(
	input wire logic clk,
	input wire logic ce,
	mrp_store_if.mem st
);

	// Macro bodies, one fixed region of entries per slot
	mrp_entry_t mem [`MRP_SLOTS*`MRP_ENTRIES];

	always_ff @(posedge clk)
	begin
		if (ce && st.wr_en)
		begin
			mem[st.wr_addr] <= st.wr_data;
		end
	end

	assign st.rd_data = mem[st.rd_addr];

endmodule

// [mrp_macro_engine_sva.sv]
`timescale 1ns/1ps
`include "mrp_map.svh"

module mrp_macro_engine_sva
	import mrp_pkg::*;
#(
	parameter int CYC_PER_MS = 4
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic restart,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic cmd_read,
	input wire logic [15:0] cmd_code,
	input wire logic rsp_valid,
	input wire logic [1:0] rsp_status,
	input wire logic exec_valid,
	input wire logic busy
);
	logic tk;
	logic tk_run;
	assign tk = ce && cmd_valid && cmd_ready;
	// Taken start request, kept as a plain signal for sampling
	assign tk_run = tk && cmd_code == 16'hE010 && !cmd_read;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	answer_next_a: assert property (
		tk && !cmd_read |=> rsp_valid || exec_valid)
		else $error("taken write got no answer");
	// A list or show query that is not answered at once closes the port
	list_block_a: assert property (
		tk && cmd_read && cmd_code == 16'hE003 ##1 !rsp_valid
		|-> !cmd_ready) else $error("list did not hold port");
	show_block_a: assert property (
		tk && cmd_read && cmd_code == 16'hE004 ##1 !rsp_valid
		|-> !cmd_ready) else $error("show did not hold port");
	stop_idle_a: assert property (
		tk && !cmd_read && cmd_code == 16'hE011
		|=> ##[0:1] !busy) else $error("stop left macro running");
	stop_ok_a: assert property (
		tk && !cmd_read && cmd_code == 16'hE011
		|=> rsp_valid && rsp_status == 2'h0) else $error("stop not answered");
	busy_ready_a: assert property (busy |-> cmd_ready)
		else $error("port closed while running");
	busy_cause_a: assert property ($rose(busy)
		|-> $past(tk) || $past(restart) || $past(restart, 2))
		else $error("run began without cause");
	exec_cause_a: assert property (exec_valid
		|-> busy || $past(busy) || $past(tk)) else $error("stray exec pulse");
	unknown_idle_a: assert property (
		rsp_valid && rsp_status == 2'h1 && !$past(busy) && $past(tk_run)
		|-> !busy) else $error("unknown name started a run");
endmodule

bind mrp_macro_engine mrp_macro_engine_sva #(.CYC_PER_MS(CYC_PER_MS)) sva_u (
	.clk(clk), .rst(rst), .ce(ce), .restart(restart),
	.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
	.cmd_code(cmd_code), .rsp_valid(rsp_valid), .rsp_status(rsp_status),
	.exec_valid(exec_valid), .busy(busy));

// [mrp_host_model.sv]
`timescale 1ns/1ps
`include "mrp_map.svh"

module mrp_host_model
(
	input wire logic clk,
	input wire logic cmd_ready,
	output logic cmd_valid,
	output logic [1:0] cmd_src,
	output logic cmd_read,
	output logic [15:0] cmd_code,
	output logic cmd_has_name,
	output logic [63:0] cmd_name,
	output logic cmd_has_arg,
	output logic [31:0] cmd_arg
);
	initial
		{cmd_valid, cmd_src, cmd_read, cmd_code, cmd_has_name, cmd_name,
			cmd_has_arg, cmd_arg} = '0;

	// Offer one command and hold it until the taking edge
	task automatic send(input logic [1:0] s, input logic rd,
		input logic [15:0] c, input logic [63:0] n, input logic [31:0] a);
		int i;
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_src <= s;
		cmd_read <= rd;
		cmd_code <= c;
		cmd_has_name <= |n;
		cmd_name <= n;
		cmd_has_arg <= |a;
		cmd_arg <= a;
		i = 0;
		do
		begin
			@(posedge clk);
			i++;
		end
		while (cmd_ready !== 1'b1 && i < 200);
		// Released code, name and argument lines must not keep the old value
		cmd_valid <= 1'b0;
		cmd_code <= ~c;
		cmd_name <= ~n;
		cmd_arg <= ~a;
	endtask
endmodule

// [tb_mrp_macro_engine.sv]
`timescale 1ns/1ps
`include "mrp_map.svh"

module tb_mrp_macro_engine;
	import mrp_pkg::*;
	localparam int CPM = 8;
	logic clk, rst, ce, restart, cmd_valid, cmd_ready, cmd_read;
	logic cmd_has_name, cmd_has_arg, rsp_valid, rsp_last, exec_valid;
	logic exec_has_name, exec_has_arg, busy;
	logic [1:0] cmd_src, rsp_status, st;
	logic [15:0] cmd_code, exec_code, last_ex;
	logic [63:0] cmd_name, exec_name;
	logic [31:0] cmd_arg, exec_arg;
	logic [127:0] rsp_data;
	logic [127:0] q[$];
	int err_count, n_tests, n_ex, cyc, t70, t71;

	mrp_macro_engine #(.CYC_PER_MS(CPM)) dut_u (.*);
	mrp_host_model host_u (.*);

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cyc++;
		if (exec_valid === 1'b1)
		begin
			n_ex++;
			last_ex = exec_code;
			if (exec_code === 16'h2070)
				t70 = cyc;
			if (exec_code === 16'h2071)
				t71 = cyc;
		end
	end

	task automatic chk(input string nm, input logic [127:0] e,
		input logic [127:0] g);
		n_tests++;
		if (g !== e)
		begin
			err_count++;
			$display("unexpected %s: expected %0h seen %0h", nm, e, g);
		end
	endtask

	// Send and gather the answer beats, or the pass-through pulse
	task automatic cmd(input logic [1:0] s, input logic rd,
		input logic [15:0] c, input logic [63:0] n, input logic [31:0] a);
		int i;
		logic got;
		host_u.send(s, rd, c, n, a);
		q.delete();
		got = 1'b0;
		for (i = 0; i < 60 && !got; i++)
		begin
			@(posedge clk);
			if (rsp_valid === 1'b1)
			begin
				q.push_back(rsp_data);
				st = rsp_status;
				got = rsp_last === 1'b1 || !(rd && (c == 16'hE003 || c == 16'hE004));
			end
			else if (i == 0 && exec_valid === 1'b1)
				got = 1'b1;
		end
		if (!got)
			chk("answer", 1, 0);
	endtask

	task automatic wait_idle;
		int i;
		for (i = 0; i < 400 && busy !== 1'b0; i++)
			@(posedge clk);
		@(posedge clk);
		chk("idle", 0, busy);
	endtask

	task automatic pulse_restart;
		@(posedge clk);
		restart <= 1'b1;
		@(posedge clk);
		restart <= 1'b0;
	endtask

	task automatic t_record;
		cmd(0, 0, 16'hE000, "AB", 0);
		chk("rec_st", 0, st);
		cmd(0, 0, 16'h2040, 0, 5);
		cmd(1, 0, 16'h2041, "SV", 7);
		chk("ex_code", 16'h2041, exec_code);
		chk("ex_arg", 7, exec_arg);
		chk("ex_name", "SV", exec_name);
		chk("ex_flags", 2'h3, {exec_has_name, exec_has_arg});
		cmd(0, 0, 16'hE012, 0, 2);
		cmd(0, 0, 16'h2042, 0, 0);
		cmd(0, 0, 16'hE002, 0, 0);
		cmd(0, 1, 16'hE004, "AB", 0);
		chk("show_n", 4, q.size());
		chk("show_c0", 16'h2040, q[0][113:98]);
		chk("show_c1", 16'hE012, q[1][113:98]);
		chk("show_arg", 2, q[1][31:0]);
		chk("show_c2", 16'h2042, q[2][113:98]);
	endtask

	task automatic t_list;
		cmd(0, 0, 16'hE000, "AB", 0);
		cmd(0, 0, 16'h2050, 0, 0);
		cmd(0, 0, 16'hE002, 0, 0);
		cmd(0, 0, 16'hE000, "ab", 0);
		cmd(0, 0, 16'h2060, 0, 0);
		cmd(0, 0, 16'hE002, 0, 0);
		cmd(0, 1, 16'hE004, "AB", 0);
		chk("ow_n", 2, q.size());
		chk("ow_c", 16'h2050, q[0][113:98]);
		cmd(0, 1, 16'hE003, 0, 0);
		chk("list_n", 3, q.size());
		chk("list_0", "AB", q[0]);
		chk("list_1", "ab", q[1]);
		chk("list_end", 0, q[2]);
	endtask

	task automatic t_run;
		n_ex = 0;
		cmd(0, 0, 16'hE010, "ab", 8);
		chk("run_busy", 1, busy);
		cmd(0, 1, 16'hE010, 0, 0);
		chk("run_stat", 1, q[0][0]);
		wait_idle;
		chk("run_n", 8, n_ex);
		chk("run_code", 16'h2060, last_ex);
		n_ex = 0;
		cmd(0, 0, 16'hE010, "AB", 0);
		wait_idle;
		chk("run_one", 1, n_ex);
		cmd(0, 0, 16'hE000, "NS", 0);
		cmd(0, 0, 16'hE010, "ab", 0);
		cmd(0, 0, 16'hE002, 0, 0);
		cmd(0, 0, 16'hE010, "NS", 0);
		wait_idle;
		chk("nest", 16'h2060, last_ex);
	endtask

	task automatic t_delay;
		cmd(0, 0, 16'hE000, "DL", 0);
		cmd(0, 0, 16'h2070, 0, 0);
		cmd(0, 0, 16'hE012, 0, 2);
		cmd(0, 0, 16'h2071, 0, 0);
		cmd(0, 0, 16'hE002, 0, 0);
		cmd(0, 0, 16'hE012, 0, 3);
		chk("host_delay", 0, {st, busy});
		cmd(0, 0, 16'hE010, "DL", 0);
		wait_idle;
		chk("gap_lo", 1, t71 - t70 >= 2 * CPM);
		chk("gap_hi", 1, t71 - t70 <= 2 * CPM + 4);
	endtask

	task automatic t_default;
		int i;
		cmd(0, 0, 16'hE005, "DL", 0);
		cmd(0, 1, 16'hE005, 0, 0);
		chk("def_v", 1, q[0][64]);
		chk("def_n", "DL", q[0][63:0]);
		t70 = 0;
		pulse_restart;
		for (i = 0; i < 10 && busy !== 1'b1; i++)
			@(posedge clk);
		chk("rs_busy", 1, busy);
		wait_idle;
		chk("rs_exec", 1, t70 != 0);
		cmd(0, 0, 16'hE005, 0, 0);
		cmd(0, 1, 16'hE005, 0, 0);
		chk("def_clr", 0, q[0][64]);
		pulse_restart;
		repeat (6) @(posedge clk);
		chk("rs_none", 0, busy);
	endtask

	task automatic t_stop;
		t71 = 0;
		cmd(0, 0, 16'hE010, "DL", 0);
		// Enable low must freeze playback well past the 2 ms pause
		ce <= 1'b0;
		repeat (40) @(posedge clk);
		chk("freeze", 2'h3, {busy, t71 == 0});
		ce <= 1'b1;
		cmd(0, 0, 16'hE011, 0, 0);
		repeat (30) @(posedge clk);
		chk("stop", 0, {busy, t71});
		cmd(0, 0, 16'hE006, "ab", 0);
		cmd(0, 1, 16'hE003, 0, 0);
		chk("del_n", 4, q.size());
		cmd(0, 0, 16'hE010, "ab", 0);
		chk("del_run", 1, st);
	endtask

	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial
	begin
		{err_count, n_tests, n_ex, cyc, t70, t71} = '0;
		rst = 1'b1;
		ce = 1'b1;
		restart = 1'b0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_record;
		t_list;
		t_run;
		t_delay;
		t_default;
		t_stop;
		wrap_up;
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		err_count++;
		wrap_up;
	end
endmodule
